//--- hw/meg_map.vh
`ifndef MEG_MAP_VH
`define MEG_MAP_VH
// Byte addresses of the enable bytes in the special-function area.
`define MEG_ADDR_UPPER_LOW 8'h2c
`define MEG_ADDR_UPPER_HIGH 8'h2d
`define MEG_ADDR_LOW 8'h3a
`define MEG_ADDR_HIGH 8'h3b
// Byte addresses of the request latch bytes.
`define MEG_ADDR_LATCH_UL 8'h2e
`define MEG_ADDR_LATCH_UH 8'h2f
`define MEG_ADDR_LATCH_L 8'h3c
`define MEG_ADDR_LATCH_H 8'h3d
// Position of the global mask gate in the low enable byte.
`define MEG_GATE_BIT 0
// Implemented enable flags per 16-bit pair; other bits read as zero, except the gate bit in the low enable byte.
`define MEG_LOW_PAIR_MASK 16'h6fd0
`define MEG_UPPER_PAIR_MASK 16'h18fe
// Latch bits that exist: sources 2 to 15 and 16 to 31.
`define MEG_LOW_LATCH_MASK 16'hfffc
`define MEG_UPPER_LATCH_MASK 16'hffff
// Non-maskable latched sources: address trap and watchdog.
`define MEG_NMI_MASK 16'h000c
// Reset values.
`define MEG_RESET_ENABLE 16'h0000
`define MEG_RESET_LATCH 16'h0000
`define MEG_RESET_GATE 1'b0
`define MEG_RESET_RDATA 8'h00
`endif

//--- hw/meg_sfr_byte.v
`include "meg_map.vh"
// One byte-addressed 16-bit register pair with an implemented-bit mask.
module meg_sfr_byte #(
  parameter [7:0] ADDR_LOW = 8'h00,
  parameter [15:0] BIT_MASK = 16'hffff
) (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_we,
  input wire [15:0] hw_clear,
  output reg [15:0] value,
  output wire hit
);
  wire hit_low;
  wire hit_high;
  reg [15:0] next_value;

  assign hit_low = (sfr_addr == ADDR_LOW);
  assign hit_high = (sfr_addr == (ADDR_LOW + 8'h01));
  assign hit = hit_low | hit_high;

  always @* begin
    next_value = value;
    if (sfr_we && hit_low) begin
      next_value[7:0] = sfr_wdata;
    end
    if (sfr_we && hit_high) begin
      next_value[15:8] = sfr_wdata;
    end
    next_value = next_value & ~hw_clear & BIT_MASK;
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      value <= `MEG_RESET_ENABLE;
    end else begin
      value <= next_value;
    end
  end
endmodule // meg_sfr_byte

//--- hw/meg_gate.v
`include "meg_map.vh"
module meg_gate (
  input wire clk,
  input wire sys_rst,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_we,
  output reg [7:0] sfr_rdata,
  output wire sfr_hit,
  input wire unmask_all_instruction,
  input wire mask_all_instruction,
  input wire [31:0] source_request,
  input wire accept,
  input wire [4:0] accept_source,
  output reg stacked_gate,
  input wire ret_instruction,
  input wire ret_gate,
  input wire nmi_soft,
  output wire [31:0] eligible,
  output wire nmi_pending,
  output wire global_mask_gate
);
  wire [15:0] low_pair;
  wire [15:0] upper_pair;
  wire hit_low_pair;
  wire hit_upper_pair;
  reg [15:0] latch_low;
  reg [15:0] latch_upper;
  reg [15:0] next_latch_low;
  reg [15:0] next_latch_upper;
  reg gate;
  reg next_gate;
  wire [31:0] accept_onehot;
  wire [31:0] enable_all;
  wire [31:0] latch_all;
  wire gate_write;
  wire hit_latch_l;
  wire hit_latch_h;
  wire hit_latch_ul;
  wire hit_latch_uh;
  wire nmi_latched;
  reg [7:0] next_rdata;

  // Enable flags are only ever changed by software, so no hardware clear
  // is wired in; the gate bit is handled separately below.
  meg_sfr_byte #(
    .ADDR_LOW(`MEG_ADDR_LOW),
    .BIT_MASK(`MEG_LOW_PAIR_MASK)
  ) u_low_pair (
    .clk(clk),
    .sys_rst(sys_rst),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata),
    .sfr_we(sfr_we),
    .hw_clear(16'h0000),
    .value(low_pair),
    .hit(hit_low_pair)
  );

  meg_sfr_byte #(
    .ADDR_LOW(`MEG_ADDR_UPPER_LOW),
    .BIT_MASK(`MEG_UPPER_PAIR_MASK)
  ) u_upper_pair (
    .clk(clk),
    .sys_rst(sys_rst),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata),
    .sfr_we(sfr_we),
    .hw_clear(16'h0000),
    .value(upper_pair),
    .hit(hit_upper_pair)
  );

  function [31:0] onehot;
    input [4:0] idx;
    begin
      onehot = 32'h00000001 << idx;
    end
  endfunction

  // One latch half: a zero written clears a bit, acceptance clears its
  // bit, and a request in the same cycle wins over both.
  function [15:0] latch_next;
    input [15:0] cur;
    input wr_low;
    input wr_high;
    input [7:0] wdata;
    input [15:0] taken;
    input [15:0] raised;
    input [15:0] exists;
    reg [15:0] tmp;
    begin
      tmp = cur;
      if (wr_low) begin
        tmp[7:0] = cur[7:0] & wdata;
      end
      if (wr_high) begin
        tmp[15:8] = cur[15:8] & wdata;
      end
      latch_next = ((tmp & ~taken) | raised) & exists;
    end
  endfunction

  assign accept_onehot = accept ? onehot(accept_source) : 32'h00000000;
  assign enable_all = {upper_pair, low_pair};
  assign latch_all = {latch_upper, latch_low};
  assign global_mask_gate = gate;
  assign gate_write = sfr_we && (sfr_addr == `MEG_ADDR_LOW);
  assign hit_latch_l = (sfr_addr == `MEG_ADDR_LATCH_L);
  assign hit_latch_h = (sfr_addr == `MEG_ADDR_LATCH_H);
  assign hit_latch_ul = (sfr_addr == `MEG_ADDR_LATCH_UL);
  assign hit_latch_uh = (sfr_addr == `MEG_ADDR_LATCH_UH);

  // Gate bit is held here, not in the pair, so acceptance can clear it.
  // Later assignments win: acceptance beats a return, a return beats the
  // mask and unmask operations, and those beat a register write.
  // A write that sets the gate and flags together is taken as written;
  // keeping the two apart is left to software.
  always @* begin
    next_gate = gate;
    if (gate_write) begin
      next_gate = sfr_wdata[`MEG_GATE_BIT];
    end
    if (unmask_all_instruction) begin
      next_gate = 1'b1;
    end
    if (mask_all_instruction) begin
      next_gate = 1'b0;
    end
    if (ret_instruction) begin
      next_gate = ret_gate;
    end
    if (accept) begin
      next_gate = 1'b0;
    end
  end

  // Only the value pushed at the latest acceptance is kept here; deeper
  // nesting relies on the core's own stack for older values.
  always @(posedge clk) begin
    if (sys_rst) begin
      gate <= `MEG_RESET_GATE;
      stacked_gate <= `MEG_RESET_GATE;
    end else begin
      gate <= next_gate;
      if (accept) begin
        stacked_gate <= gate;
      end
    end
  end

  always @* begin
    next_latch_low = latch_next(latch_low, sfr_we && hit_latch_l,
      sfr_we && hit_latch_h, sfr_wdata, accept_onehot[15:0],
      source_request[15:0], `MEG_LOW_LATCH_MASK);
    next_latch_upper = latch_next(latch_upper, sfr_we && hit_latch_ul,
      sfr_we && hit_latch_uh, sfr_wdata, accept_onehot[31:16],
      source_request[31:16], `MEG_UPPER_LATCH_MASK);
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      latch_low <= `MEG_RESET_LATCH;
      latch_upper <= `MEG_RESET_LATCH;
    end else begin
      latch_low <= next_latch_low;
      latch_upper <= next_latch_upper;
    end
  end

  // Latches 2 and 3 have no enable bit, so they never show in the
  // eligible vector; they reach the core through nmi_pending instead.
  assign eligible = latch_all & enable_all &
    {32{gate}};
  // Trap and watchdog latches bypass every enable; accepting them still
  // clears the gate like any other source.
  assign nmi_latched = |(latch_low & `MEG_NMI_MASK);
  assign nmi_pending = nmi_soft | nmi_latched;
  assign sfr_hit = hit_low_pair | hit_upper_pair | hit_latch_l |
    hit_latch_h | hit_latch_ul | hit_latch_uh;

  // The read value is picked from this cycle's address and held in a
  // register, so read data is valid the cycle after the address.
  always @* begin
    case (sfr_addr)
      `MEG_ADDR_LOW: next_rdata = {low_pair[7:1], gate};
      `MEG_ADDR_HIGH: next_rdata = low_pair[15:8];
      `MEG_ADDR_UPPER_LOW: next_rdata = upper_pair[7:0];
      `MEG_ADDR_UPPER_HIGH: next_rdata = upper_pair[15:8];
      `MEG_ADDR_LATCH_L: next_rdata = latch_low[7:0];
      `MEG_ADDR_LATCH_H: next_rdata = latch_low[15:8];
      `MEG_ADDR_LATCH_UL: next_rdata = latch_upper[7:0];
      `MEG_ADDR_LATCH_UH: next_rdata = latch_upper[15:8];
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      sfr_rdata <= `MEG_RESET_RDATA;
    end else begin
      sfr_rdata <= next_rdata;
    end
  end
endmodule // meg_gate

//--- test/meg_cpu_model.sv
// Core side: accepts a source and returns from its handler on command.
module meg_cpu_model (
  input wire clk,
  input wire take,
  input wire [4:0] take_src,
  input wire give_back,
  input wire stacked_gate,
  output reg accept = 1'b0,
  output reg [4:0] accept_source = 5'h00,
  output reg ret_instruction = 1'b0,
  output reg ret_gate = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  reg pushed = 1'b0;
  // The stacked word is taken from the device one cycle after acceptance.
  always @(posedge clk) begin
    accept <= take;
    accept_source <= take_src;
    ret_instruction <= give_back;
    pushed <= accept;
    if (pushed) ret_gate <= stacked_gate;
  end
endmodule // meg_cpu_model

//--- test/meg_gate_asserts.sv
module meg_gate_asserts (
  input wire clk, input wire sys_rst, input wire accept,
  input wire ret_instruction, input wire ret_gate, input wire nmi_soft,
  input wire mask_all_instruction, input wire unmask_all_instruction,
  input wire [31:0] eligible, input wire nmi_pending,
  input wire stacked_gate, input wire global_mask_gate
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  gate_reset_a: assert property (disable iff (1'b0)
    sys_rst |=> !global_mask_gate) else $error("gate set after reset");
  gate_blocks_a: assert property (
    !global_mask_gate |-> eligible == 32'h0)
    else $error("eligible while gate low");
  nmi_bypass_a: assert property (nmi_soft |-> nmi_pending)
    else $error("nmi not pending");
  accept_clears_a: assert property (
    accept |=> !global_mask_gate) else $error("gate kept on accept");
  accept_saves_a: assert property (accept |=>
    stacked_gate == $past(global_mask_gate)) else $error("gate not saved");
  ret_restores_a: assert property (
    ret_instruction && !accept |=> global_mask_gate == $past(ret_gate))
    else $error("gate not restored");
  mask_op_a: assert property (
    mask_all_instruction && !accept && !ret_instruction |=> !global_mask_gate)
    else $error("mask op ignored");
  unmask_op_a: assert property (unmask_all_instruction &&
    !(accept || ret_instruction || mask_all_instruction) |=> global_mask_gate)
    else $error("unmask op ignored");
  cover property (accept);
  cover property (ret_instruction);
  cover property (eligible != 32'h0);
  cover property (nmi_pending && !global_mask_gate);
endmodule // meg_gate_asserts
bind meg_gate meg_gate_asserts u_chk (.clk(clk), .sys_rst(sys_rst),
  .accept(accept), .ret_instruction(ret_instruction), .ret_gate(ret_gate),
  .nmi_soft(nmi_soft), .mask_all_instruction(mask_all_instruction),
  .unmask_all_instruction(unmask_all_instruction), .eligible(eligible),
  .nmi_pending(nmi_pending), .stacked_gate(stacked_gate),
  .global_mask_gate(global_mask_gate));

//--- test/meg_gate_tb_top.sv
module meg_gate_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, sys_rst = 1, we = 0, unmask = 0, mask = 0, nmi = 0;
  logic take = 0, back = 0, hit, acc, stk, ret, rgate, pend, gate;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [31:0] req = 32'h0, elig;
  logic [4:0] src = 5'h04, asrc;
  logic [7:0] adr [4] = '{8'h3a, 8'h3b, 8'h2c, 8'h2d};
  logic [7:0] msk [4] = '{8'hd0, 8'h6e, 8'hfe, 8'h18};
  int mismatches = 0, cmp_count = 0, cycles = 0;
  always #4 clk = ~clk;
  meg_gate dut (.clk(clk), .sys_rst(sys_rst), .sfr_addr(addr),
    .sfr_wdata(wdata), .sfr_we(we), .sfr_rdata(rdata), .sfr_hit(hit),
    .unmask_all_instruction(unmask), .mask_all_instruction(mask),
    .source_request(req), .accept(acc), .accept_source(asrc),
    .stacked_gate(stk), .ret_instruction(ret), .ret_gate(rgate),
    .nmi_soft(nmi), .eligible(elig), .nmi_pending(pend),
    .global_mask_gate(gate));
  meg_cpu_model cpu (.clk(clk), .take(take), .take_src(src),
    .give_back(back), .stacked_gate(stk), .accept(acc),
    .accept_source(asrc), .ret_instruction(ret), .ret_gate(rgate));
  task end_of_test;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      end_of_test;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    we = 1;
    cyc(1);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    we = 0;
    cyc(1);
    chk(rdata, e);
  endtask
  initial begin
    cyc(12);
    sys_rst = 0;
    foreach (adr[i]) rd(adr[i], 8'h00);
    // Bit 0 stays clear so the gate and flags are never set together.
    foreach (adr[i]) wr(adr[i], 8'hfe);
    foreach (adr[i]) rd(adr[i], msk[i]);
    chk(hit, 1'b1);
    rd(8'h40, 8'h00);
    chk(hit, 1'b0);
    chk(gate, 1'b0);
    req = 32'h0010_0010;
    cyc(1);
    req = 32'h0;
    chk(elig, 32'h0);
    unmask = 1;
    cyc(1);
    unmask = 0;
    chk(elig, 32'h0010_0010);
    take = 1;
    cyc(1);
    take = 0;
    cyc(1);
    chk(gate, 1'b0);
    chk(stk, 1'b1);
    // The handler changes its flags while the gate is still low.
    wr(8'h3b, 8'h00);
    rd(8'h3b, 8'h00);
    back = 1;
    cyc(1);
    back = 0;
    cyc(1);
    chk(gate, 1'b1);
    chk(elig, 32'h0010_0000);
    mask = 1;
    cyc(1);
    mask = 0;
    chk(gate, 1'b0);
    wr(8'h2c, 8'h00);
    wr(8'h3a, 8'h01);
    rd(8'h3a, 8'h01);
    chk(elig, 32'h0);
    nmi = 1;
    cyc(1);
    chk(pend, 1'b1);
    nmi = 0;
    cyc(1);
    chk(pend, 1'b0);
    // Trap and watchdog latches must pass with the gate and the low-pair flags all clear.
    req = 32'h0000_00fc;
    wr(8'h3a, 8'h00);
    req = 32'h0;
    chk(pend, 1'b1);
    chk(elig, 32'h0);
    rd(8'h3c, 8'hfc);
    wr(8'h3c, 8'h0c);
    rd(8'h3c, 8'h0c);
    end_of_test;
  end
endmodule // meg_gate_tb_top
